// *** bench/iosel_far_side.sv ***
// Far-side model: peripheral functions and pads of both ports.
// Assumes the bench sets pad levels and asks for a short glitch on port one.
`timescale 1ns/1ps
`default_nettype none
module iosel_far_side (
	input wire logic pclk,
	input wire logic glitch_req,
	input wire logic [31:0] glitch_mask,
	input wire logic [31:0] pad_lvl [iosel_pkg::NUM_PORTS],
	output logic [31:0] pad_in [iosel_pkg::NUM_PORTS],
	output iosel_pkg::iosel_funcs_s periph_out [iosel_pkg::NUM_PORTS]
);
	logic [31:0] glitch_ff = 32'h00000000;

	// --------------------------------------------------------------
	// Pads
	// --------------------------------------------------------------
	// 40 ns pulse across the next edge, so it is sampled exactly once
	always @(posedge pclk)
	begin
		if (glitch_req)
		begin
			#80 glitch_ff = glitch_mask;
			#40 glitch_ff = 32'h00000000;
		end
	end

	// Each function drives its own pattern, so a wrong route shows
	always_comb
	begin
		for (int p = 0; p < iosel_pkg::NUM_PORTS; p++)
		begin
			pad_in[p] = pad_lvl[p] ^ ((p == 0) ? glitch_ff : 32'h00000000);
			// A and B, C and D differ on every line, so low lines are covered too
			periph_out[p].a = 32'h0ff00ff0 ^ 32'(p);
			periph_out[p].b = 32'hf00ff00f ^ 32'(p);
			periph_out[p].c = 32'h3c3c3c3c ^ 32'(p);
			periph_out[p].d = 32'hc3c3c3c3 ^ 32'(p);
		end
	end
endmodule : iosel_far_side
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the function select and filter block.
// Assumes iosel_far_side as pads and peripherals, APB master in tasks.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [31:0] FH = iosel_pkg::ADDR_FSEL_HIGH;
	localparam logic [31:0] FL = iosel_pkg::ADDR_FSEL_LOW;
	localparam logic [31:0] GC = iosel_pkg::ADDR_GLITCH_CHOOSE;
	localparam logic [31:0] DC = iosel_pkg::ADDR_DEBOUNCE_CHOOSE;
	localparam logic [31:0] KS = iosel_pkg::ADDR_KIND_STATUS;
	localparam logic [31:0] DV = iosel_pkg::ADDR_DIVIDER;
	localparam logic [31:0] PU = iosel_pkg::ADDR_PULLUP_STATUS;
	localparam logic [31:0] P2 = iosel_pkg::PORT_STRIDE;
	// Patterns the far-side functions A to D drive on port one
	localparam logic [31:0] FN [4] = '{32'h0ff00ff0, 32'hf00ff00f, 32'h3c3c3c3c, 32'hc3c3c3c3};
	logic pclk = 1'b0;
	logic slow_clk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h00000000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic wpe = 1'b0;
	logic glitch_req = 1'b0;
	logic [31:0] pullup_on [iosel_pkg::NUM_PORTS];
	logic [31:0] filter_enable [iosel_pkg::NUM_PORTS];
	logic [31:0] pad_lvl [iosel_pkg::NUM_PORTS];
	logic [31:0] pad_in [iosel_pkg::NUM_PORTS];
	logic [31:0] pad_out [iosel_pkg::NUM_PORTS];
	iosel_pkg::iosel_funcs_s periph_out [iosel_pkg::NUM_PORTS];
	iosel_pkg::iosel_funcs_s periph_in [iosel_pkg::NUM_PORTS];
	iosel_pkg::iosel_funcs_s e;
	logic [31:0] rd;
	logic err;
	logic seen0;
	logic seen1;
	int fails = 0;
	int samples_checked = 0;

	always #50 pclk = ~pclk;
	// Slow clock of seven pclk periods, its rising edges landing on pclk rising edges
	always #350 slow_clk = ~slow_clk;

	iosel_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slow_clk(slow_clk),
		.write_protect_enable(wpe), .pullup_on(pullup_on),
		.filter_enable(filter_enable), .pad_in(pad_in), .periph_out(periph_out),
		.periph_in(periph_in), .pad_out(pad_out));

	iosel_far_side far (.pclk(pclk), .glitch_req(glitch_req), .glitch_mask(32'h00000003),
		.pad_lvl(pad_lvl), .pad_in(pad_in), .periph_out(periph_out));

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
		samples_checked++;
		if (got !== ex)
		begin
			$display("ERROR %s expected %h seen %h", nm, ex, got);
			fails++;
		end
	endtask : chk

	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk("pready", 1, 0);
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
		chk("write error", 0, err);
	endtask : wr

	task automatic rdc(input logic [31:0] a, input logic [31:0] ex, input string nm);
		xfer(a, 1'b0, 32'h00000000);
		chk(nm, {1'b0, ex}, {err, rd});
	endtask : rdc

	task automatic watch(input int n);
		seen0 = 1'b0;
		seen1 = 1'b0;
		repeat (n)
		begin
			@(posedge pclk);
			seen0 = seen0 | periph_in[0].a[0];
			seen1 = seen1 | periph_in[0].a[1];
		end
	endtask : watch

	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial
	begin
		pullup_on[0] = 32'h0f0f00ff;
		pullup_on[1] = 32'h12345678;
		filter_enable[0] = 32'h00000000;
		filter_enable[1] = 32'h00000000;
		pad_lvl[0] = 32'h5a5aa5a4;
		pad_lvl[1] = 32'h00000000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(FH, 32'h00000000, "fsel high reset");
		rdc(FL, 32'h00000000, "fsel low reset");
		rdc(KS, 32'h00000000, "kind reset");
		rdc(DV, 32'h00000000, "divider reset");
		rdc(PU, 32'hf0f0ff00, "pullup one");
		rdc(PU + P2, 32'hedcba987, "pullup two");
		xfer(FH + 32'h0000000c, 1'b0, 32'h00000000);
		chk("unmapped error", 1, err);
		rdc(GC, 32'h00000000, "write-only read");
		wr(FH, 32'h89abcdef);
		wr(FL, 32'h76543210);
		rdc(FH, 32'h89abcdef, "fsel high");
		rdc(FL, 32'h76543210, "fsel low");
		rdc(FH + P2, 32'h00000000, "fsel high two");
		wr(FH + P2, 32'h0000ffff);
		rdc(FH + P2, 32'h0000ffff, "fsel high two");
		wpe <= 1'b1;
		wr(FH, 32'h00000000);
		wr(FL, 32'h00000000);
		rdc(FH, 32'h89abcdef, "protected high");
		rdc(FL, 32'h76543210, "protected low");
		wr(FL + P2, 32'hffffffff);
		rdc(FL + P2, 32'h00000000, "protected low two");
		wpe <= 1'b0;
		wr(FH + P2, 32'h00000000);
		wr(DV, 32'hffffffff);
		rdc(DV, (32'h1 << iosel_pkg::DIV_W) - 32'h1, "divider field");
		wr(DC, 32'h000000f0);
		rdc(KS, 32'h000000f0, "kind debounce");
		wr(DC + P2, 32'h0000000f);
		rdc(KS + P2, 32'h0000000f, "kind two");
		wr(GC, 32'h00000030);
		wr(DC, 32'h00000000);
		wr(GC, 32'h00000000);
		rdc(KS, 32'h000000c0, "kind glitch");
		wr(KS, 32'hffffffff);
		rdc(KS, 32'h000000c0, "kind read-only");
		wr(GC, 32'hffffffff);
		$display("test registers done");
		for (int k = 3; k >= 0; k--)
		begin
			wr(FL, k[0] ? 32'hffffffff : 32'h00000000);
			wr(FH, k[1] ? 32'hffffffff : 32'h00000000);
			repeat (4) @(posedge pclk);
			e = '0;
			e[k*32 +: 32] = pad_lvl[0];
			chk("periph_in route", e, periph_in[0]);
			chk("pad_out route", FN[k], pad_out[0]);
			chk("pad_out two", FN[0] ^ 32'h00000001, pad_out[1]);
		end
		wr(FL + P2, 32'h00000020);
		repeat (3) @(posedge pclk);
		chk("pad_out two b", 32'h0ff00fd1, pad_out[1]);
		$display("test routing done");
		filter_enable[0] <= 32'h00000001;
		pad_lvl[0] <= 32'h00000000;
		repeat (10) @(posedge pclk);
		glitch_req <= 1'b1;
		@(posedge pclk);
		glitch_req <= 1'b0;
		watch(12);
		chk("glitch filtered", 0, seen0);
		chk("bypass passes", 1, seen1);
		pad_lvl[0] <= 32'h00000001;
		repeat (8) @(posedge pclk);
		chk("glitch steady", 1, periph_in[0].a[0]);
		pad_lvl[0] <= 32'h00000000;
		wr(DV, 32'h00000001);
		wr(DC, 32'h00000001);
		repeat (60) @(posedge pclk);
		// 1000 ns pulse against 1400 ns tick spacing
		pad_lvl[0] <= 32'h00000001;
		repeat (10) @(posedge pclk);
		pad_lvl[0] <= 32'h00000000;
		watch(40);
		chk("debounce pulse", 0, seen0);
		pad_lvl[0] <= 32'h00000001;
		repeat (60) @(posedge pclk);
		chk("debounce steady", 1, periph_in[0].a[0]);
		$display("test filters done");
		results();
	end

	initial
	begin
		#1000000;
		fails++;
		results();
	end
endmodule : tb
`default_nettype wire

// *** rtl/iosel_filter.sv ***
// One line's input filter: glitch stage, debounce stage, bypass.
// Assumes din is already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
module iosel_filter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	input wire logic deb_tick,
	input wire logic use_deb,
	input wire logic filt_en,
	output logic dout
);
	logic prev_ff;
	logic glitch_ff;
	logic samp_ff;
	logic deb_ff;
	logic dout_ff;

	// --------------------------------------------------------------
	// Glitch stage
	// --------------------------------------------------------------
	// Level must hold two samples, so sub half-period pulses die
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_ff <= 1'b0;
			glitch_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= din;
			if (din == prev_ff)
				glitch_ff <= din;
		end
	end

	// --------------------------------------------------------------
	// Debounce stage, sampled at each divided half-period
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			samp_ff <= 1'b0;
			deb_ff <= 1'b0;
		end
		else if (deb_tick)
		begin
			samp_ff <= din;
			if (din == samp_ff)
				deb_ff <= din;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dout_ff <= 1'b0;
		else if (!filt_en)
			dout_ff <= din;
		else
			dout_ff <= use_deb ? deb_ff : glitch_ff;
	end

	assign dout = dout_ff;

	AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
		!filt_en |=> dout_ff == $past(din))
		else $error("unfiltered line did not follow input");
	AST_DEB_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!deb_tick |=> $stable(deb_ff))
		else $error("debounce level moved between ticks");
endmodule : iosel_filter
`default_nettype wire

// *** rtl/iosel_pkg.sv ***
// Constants and carrier types for the line function select and filter block.
// Assumes a 32-bit APB and two identical port controllers.
//
// Function
// - Pull-up status reads 0 when enabled
// - Two select bits route line to A-D
// - Both select registers read/write, bit per line
// - Select writes ignored while protection enabled
// - Glitch choose write 1 selects glitch filter
// - Debounce choose write 1 selects debouncer
// - Glitch filter drops sub half-clock pulses
// - Debouncer drops sub half divided-period pulses
// - Kind status: 0 glitch, 1 debounce
// - Divider register holds low-order divider field
// - Two port copies, bases 0x200 apart
// - Debounce period is (div+1)*2 slow periods
package iosel_pkg;
	localparam int NUM_PORTS = 2;
	localparam int NUM_LINES = 32;
	localparam int DIV_W = 14;
	localparam int SYNC_STAGES = 2;

	// --------------------------------------------------------------
	// Register addresses of the first port
	// --------------------------------------------------------------
	localparam logic [31:0] ADDR_PULLUP_STATUS = 32'h400e0e68;
	localparam logic [31:0] ADDR_FSEL_HIGH = 32'h400e0e70;
	localparam logic [31:0] ADDR_FSEL_LOW = 32'h400e0e74;
	localparam logic [31:0] ADDR_GLITCH_CHOOSE = 32'h400e0e80;
	localparam logic [31:0] ADDR_DEBOUNCE_CHOOSE = 32'h400e0e84;
	localparam logic [31:0] ADDR_KIND_STATUS = 32'h400e0e88;
	localparam logic [31:0] ADDR_DIVIDER = 32'h400e0e8c;
	localparam logic [31:0] PORT_STRIDE = 32'h00000200;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [31:0] RST_FSEL = 32'h00000000;
	localparam logic [31:0] RST_KIND = 32'h00000000;
	localparam logic [DIV_W-1:0] RST_DIV = 14'h0000;

	typedef struct packed {
		logic [31:0] d;
		logic [31:0] c;
		logic [31:0] b;
		logic [31:0] a;
	} iosel_funcs_s;
endpackage : iosel_pkg

// *** rtl/iosel_top.sv ***
// Function select and input filter selection for two I/O ports.
// Assumes an APB master on pclk; pads and slow clock are asynchronous,
// pull-up, protect and filter-enable levels come from pclk neighbours.
`timescale 1ns/1ps
`default_nettype none
module iosel_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_clk,
	input wire logic write_protect_enable,
	input wire logic [31:0] pullup_on [iosel_pkg::NUM_PORTS],
	input wire logic [31:0] filter_enable [iosel_pkg::NUM_PORTS],
	input wire logic [31:0] pad_in [iosel_pkg::NUM_PORTS],
	input wire iosel_pkg::iosel_funcs_s periph_out [iosel_pkg::NUM_PORTS],
	output iosel_pkg::iosel_funcs_s periph_in [iosel_pkg::NUM_PORTS],
	output logic [31:0] pad_out [iosel_pkg::NUM_PORTS]
);
	localparam int NP = iosel_pkg::NUM_PORTS;
	localparam int NL = iosel_pkg::NUM_LINES;
	localparam int DW = iosel_pkg::DIV_W;

	logic [31:0] fsel_low_ff [NP];
	logic [31:0] fsel_high_ff [NP];
	logic [31:0] kind_ff [NP];
	logic [DW-1:0] div_ff [NP];
	logic [DW-1:0] div_cnt_ff [NP];
	logic [NP-1:0] deb_tick_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] pad_s1_ff [NP];
	logic [31:0] pad_s2_ff [NP];
	logic [31:0] filt [NP];
	logic slow_s1_ff;
	logic slow_s2_ff;
	logic slow_s3_ff;
	logic slow_rise;
	iosel_pkg::iosel_funcs_s periph_in_ff [NP];
	logic [31:0] pad_out_ff [NP];

	// Decoded access
	logic hit_pu [NP];
	logic hit_hi [NP];
	logic hit_lo [NP];
	logic hit_gl [NP];
	logic hit_db [NP];
	logic hit_ks [NP];
	logic hit_dv [NP];
	logic any_hit;
	logic wr_go;
	logic fsel_wr_ok;
	logic [31:0] nxt_prdata;

	// --------------------------------------------------------------
	// Address decode
	// --------------------------------------------------------------
	always_comb
	begin
		logic [31:0] base;
		base = 32'h00000000;
		any_hit = 1'b0;
		for (int p = 0; p < NP; p++)
		begin
			base = iosel_pkg::PORT_STRIDE * p[31:0];
			hit_pu[p] = paddr == iosel_pkg::ADDR_PULLUP_STATUS + base;
			hit_hi[p] = paddr == iosel_pkg::ADDR_FSEL_HIGH + base;
			hit_lo[p] = paddr == iosel_pkg::ADDR_FSEL_LOW + base;
			hit_gl[p] = paddr == iosel_pkg::ADDR_GLITCH_CHOOSE + base;
			hit_db[p] = paddr == iosel_pkg::ADDR_DEBOUNCE_CHOOSE + base;
			hit_ks[p] = paddr == iosel_pkg::ADDR_KIND_STATUS + base;
			hit_dv[p] = paddr == iosel_pkg::ADDR_DIVIDER + base;
			any_hit = any_hit | hit_pu[p] | hit_hi[p] | hit_lo[p] | hit_gl[p]
				| hit_db[p] | hit_ks[p] | hit_dv[p];
		end
	end

	// --------------------------------------------------------------
	// Read mux
	// --------------------------------------------------------------
	// Write-only registers read back as zero
	always_comb
	begin
		nxt_prdata = 32'h00000000;
		for (int p = 0; p < NP; p++)
		begin
			if (hit_pu[p])
				nxt_prdata = ~pullup_on[p];
			if (hit_hi[p])
				nxt_prdata = fsel_high_ff[p];
			if (hit_lo[p])
				nxt_prdata = fsel_low_ff[p];
			if (hit_ks[p])
				nxt_prdata = kind_ff[p];
			if (hit_dv[p])
				nxt_prdata = {{(32 - DW){1'b0}}, div_ff[p]};
		end
	end

	// --------------------------------------------------------------
	// APB handshake
	// --------------------------------------------------------------
	// Answer prepared in the setup cycle so every bus output is a flop;
	// the access phase therefore always completes in its first cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end
		else
		begin
			pready_ff <= psel & ~penable;
			if (psel & ~penable)
			begin
				pslverr_ff <= ~any_hit;
				prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
			end
			else
			begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	assign wr_go = psel & penable & pwrite & pready_ff;
	assign fsel_wr_ok = wr_go & ~write_protect_enable;

	// --------------------------------------------------------------
	// Function select registers
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NP; p++)
			begin
				fsel_low_ff[p] <= iosel_pkg::RST_FSEL;
				fsel_high_ff[p] <= iosel_pkg::RST_FSEL;
			end
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				if (fsel_wr_ok && hit_lo[p])
					fsel_low_ff[p] <= pwdata;
				if (fsel_wr_ok && hit_hi[p])
					fsel_high_ff[p] <= pwdata;
			end
		end
	end

	// --------------------------------------------------------------
	// Filter kind and divider registers
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NP; p++)
			begin
				kind_ff[p] <= iosel_pkg::RST_KIND;
				div_ff[p] <= iosel_pkg::RST_DIV;
			end
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				if (wr_go && hit_gl[p])
					kind_ff[p] <= kind_ff[p] & ~pwdata;
				if (wr_go && hit_db[p])
					kind_ff[p] <= kind_ff[p] | pwdata;
				if (wr_go && hit_dv[p])
					div_ff[p] <= pwdata[DW-1:0];
			end
		end
	end

	// --------------------------------------------------------------
	// Slow clock sampling
	// --------------------------------------------------------------
	// Slow clock is only sampled, never used as a clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slow_s1_ff <= 1'b0;
			slow_s2_ff <= 1'b0;
			slow_s3_ff <= 1'b0;
		end
		else
		begin
			slow_s1_ff <= slow_clk;
			slow_s2_ff <= slow_s1_ff;
			slow_s3_ff <= slow_s2_ff;
		end
	end

	assign slow_rise = slow_s2_ff & ~slow_s3_ff;

	// --------------------------------------------------------------
	// Debounce divider
	// --------------------------------------------------------------
	// A tick every div+1 slow rising edges marks each half of the divided period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			deb_tick_ff <= '0;
			for (int p = 0; p < NP; p++)
				div_cnt_ff[p] <= '0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				deb_tick_ff[p] <= 1'b0;
				if (slow_rise)
				begin
					if (div_cnt_ff[p] >= div_ff[p])
					begin
						div_cnt_ff[p] <= '0;
						deb_tick_ff[p] <= 1'b1;
					end
					else
					begin
						div_cnt_ff[p] <= div_cnt_ff[p] + 1'b1;
					end
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Pad synchronisers
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NP; p++)
			begin
				pad_s1_ff[p] <= 32'h00000000;
				pad_s2_ff[p] <= 32'h00000000;
			end
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				pad_s1_ff[p] <= pad_in[p];
				pad_s2_ff[p] <= pad_s1_ff[p];
			end
		end
	end

	// --------------------------------------------------------------
	// Per-line filters
	// --------------------------------------------------------------
	for (genvar gp = 0; gp < NP; gp++)
	begin : g_port
		for (genvar gl = 0; gl < NL; gl++)
		begin : g_line
			iosel_filter u_filt (
				.pclk(pclk),
				.presetn(presetn),
				.din(pad_s2_ff[gp][gl]),
				.deb_tick(deb_tick_ff[gp]),
				.use_deb(kind_ff[gp][gl]),
				.filt_en(filter_enable[gp][gl]),
				.dout(filt[gp][gl])
			);
		end
	end

	// --------------------------------------------------------------
	// Function routing
	// --------------------------------------------------------------
	// Unselected peripherals see zero on the line
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int p = 0; p < NP; p++)
			begin
				periph_in_ff[p] <= '0;
				pad_out_ff[p] <= 32'h00000000;
			end
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				for (int l = 0; l < NL; l++)
				begin
					periph_in_ff[p].a[l] <= filt[p][l] & ~fsel_low_ff[p][l] & ~fsel_high_ff[p][l];
					periph_in_ff[p].b[l] <= filt[p][l] & fsel_low_ff[p][l] & ~fsel_high_ff[p][l];
					periph_in_ff[p].c[l] <= filt[p][l] & ~fsel_low_ff[p][l] & fsel_high_ff[p][l];
					periph_in_ff[p].d[l] <= filt[p][l] & fsel_low_ff[p][l] & fsel_high_ff[p][l];
					case ({fsel_high_ff[p][l], fsel_low_ff[p][l]})
						2'h0: pad_out_ff[p][l] <= periph_out[p].a[l];
						2'h1: pad_out_ff[p][l] <= periph_out[p].b[l];
						2'h2: pad_out_ff[p][l] <= periph_out[p].c[l];
						2'h3: pad_out_ff[p][l] <= periph_out[p].d[l];
						default: pad_out_ff[p][l] <= 1'b0;
					endcase
				end
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign periph_in = periph_in_ff;
	assign pad_out = pad_out_ff;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_ROUTE_B: assert property (
		fsel_low_ff[1][5] && !fsel_high_ff[1][5] && $stable(fsel_low_ff[1])
		|=> pad_out_ff[1][5] == $past(periph_out[1].b[5]))
		else $error("line not routed to function B");
	AST_ROUTE_C: assert property (
		!fsel_low_ff[0][0] && fsel_high_ff[0][0]
		|=> pad_out_ff[0][0] == $past(periph_out[0].c[0]))
		else $error("line not routed to function C");
	AST_FSEL_WR: assert property (
		wr_go && !write_protect_enable && hit_lo[0]
		|=> fsel_low_ff[0] == $past(pwdata))
		else $error("select write not stored");
	AST_PROTECT: assert property (
		wr_go && write_protect_enable && (hit_hi[1] || hit_lo[1])
		|=> $stable(fsel_high_ff[1]) && $stable(fsel_low_ff[1]))
		else $error("protected select write changed register");
	AST_GLITCH_SEL: assert property (
		wr_go && hit_gl[0] |=> kind_ff[0] == ($past(kind_ff[0]) & ~$past(pwdata)))
		else $error("glitch choose write wrong");
	AST_DEB_SEL: assert property (
		wr_go && hit_db[1] |=> kind_ff[1] == ($past(kind_ff[1]) | $past(pwdata)))
		else $error("debounce choose write wrong");
	AST_KIND_RD: assert property (
		psel && !penable && !pwrite && hit_ks[0]
		|=> pready_ff && prdata_ff == $past(kind_ff[0]))
		else $error("kind status read wrong");
	AST_PULLUP_RD: assert property (
		psel && !penable && !pwrite && hit_pu[1]
		|=> prdata_ff == ~$past(pullup_on[1]))
		else $error("pull-up status read wrong");
	AST_DIV_TICK: assert property (
		slow_rise && div_cnt_ff[0] >= div_ff[0] |=> deb_tick_ff[0])
		else $error("debounce tick missing");
	AST_DIV_QUIET: assert property (
		!slow_rise |=> !deb_tick_ff[0] && !deb_tick_ff[1])
		else $error("tick without slow clock edge");
endmodule : iosel_top
`default_nettype wire
